// ### design/nopi_sync2.sv
// two-flop synchroniser for levels and toggles entering a clock domain
`timescale 1ns/1ps
module nopi_sync2 #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    logic [W-1:0] meta;

    // first stage feeds only the second stage
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            meta <= RST_VAL;
            q_out <= RST_VAL;
        end else begin
            meta <= d_in;
            q_out <= meta;
        end
    end
endmodule

// ### design/nopi_top.sv
// pin boundary: mii nibble link, async host port, interrupt and pin reset
`timescale 1ns/1ps
module nopi_top
    import nopi_pkg::*;
#(
    parameter int RST_MIN_CYCLES = RST_MIN_CYC
) (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic reset_pin_n_in,
    input wire logic tx_nibble_clock_in,
    output logic tx_valid_out,
    output logic [NIB_W-1:0] tx_data_out,
    input wire logic rx_nibble_clock_in,
    input wire logic rx_valid_in,
    input wire logic [NIB_W-1:0] rx_data_in,
    input wire logic collision_in,
    input wire logic carrier_present_in,
    input wire logic duplex_select_n_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [DATA_W-1:0] data_in,
    output logic [DATA_W-1:0] data_out,
    output logic data_oe_out,
    input wire logic chip_select_n_in,
    input wire logic read_n_in,
    input wire logic write_n_in,
    output logic int_n_out,
    input wire logic [SOCK_N-1:0] event_connect_in,
    input wire logic [SOCK_N-1:0] event_disconnect_in,
    input wire logic [SOCK_N-1:0] event_recv_in,
    input wire logic [SOCK_N-1:0] event_timeout_in
);
    localparam int PIN_W = 7 + ADDR_W + DATA_W;
    // idle pin levels: reset pin high, strobes high, no collision, no carrier, full duplex
    localparam logic [PIN_W-1:0] PIN_RST = {7'h78, 15'h0000, 8'h00};

    // pin synchronisers toward the core clock
    logic [PIN_W-1:0] pin_s;
    logic rst_pin_n_s, cs_n_s, rd_n_s, wr_n_s, col_s, carrier_s, dup_n_s;
    logic [ADDR_W-1:0] addr_s;
    logic [DATA_W-1:0] data_s;
    nopi_sync2 #(.W(PIN_W), .RST_VAL(PIN_RST)) u_pin_sync (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .d_in({reset_pin_n_in, chip_select_n_in, read_n_in, write_n_in, collision_in,
               carrier_present_in, duplex_select_n_in, addr_in, data_in}),
        .q_out(pin_s)
    );
    assign {rst_pin_n_s, cs_n_s, rd_n_s, wr_n_s, col_s, carrier_s, dup_n_s, addr_s, data_s}
        = pin_s;

    // pin reset qualification: counter only clears on rst_in or pin release
    logic [RST_CNT_W-1:0] rst_cnt, next_rst_cnt;
    logic pin_rst, core_rst, link_rst_src;
    assign pin_rst = (rst_cnt >= RST_CNT_W'(RST_MIN_CYCLES));
    assign core_rst = rst_in | pin_rst;
    always_comb begin
        next_rst_cnt = rst_cnt;
        if (rst_pin_n_s) begin
            next_rst_cnt = '0;
        end else if (!pin_rst) begin
            next_rst_cnt = rst_cnt + 1'b1;
        end
    end
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            rst_cnt <= '0;
        end else begin
            rst_cnt <= next_rst_cnt;
        end
        link_rst_src <= core_rst; // registered so the link resets see no glitch
    end

    // link domain resets and handshake crossings
    logic tx_rst, rx_rst, tx_req, tx_req_s, tx_seen, tx_ack_s;
    logic rx_byte_tgl, rx_eop_tgl;
    logic [DATA_W-1:0] rx_byte;
    logic [1:0] rx_tgl_s;
    nopi_sync2 #(.W(1)) u_tx_rst (.clock_in(tx_nibble_clock_in), .rst_in(1'b0),
        .d_in(link_rst_src), .q_out(tx_rst));
    nopi_sync2 #(.W(1)) u_rx_rst (.clock_in(rx_nibble_clock_in), .rst_in(1'b0),
        .d_in(link_rst_src), .q_out(rx_rst));
    nopi_sync2 #(.W(1)) u_req (.clock_in(tx_nibble_clock_in), .rst_in(tx_rst),
        .d_in(tx_req), .q_out(tx_req_s));
    nopi_sync2 #(.W(1)) u_ack (.clock_in(clock_in), .rst_in(core_rst),
        .d_in(tx_seen), .q_out(tx_ack_s));
    nopi_sync2 #(.W(2)) u_rxt (.clock_in(clock_in), .rst_in(core_rst),
        .d_in({rx_eop_tgl, rx_byte_tgl}), .q_out(rx_tgl_s));

    // core state
    logic [DATA_W-1:0] tx_mem [MEM_DEPTH];
    logic [DATA_W-1:0] rx_mem [MEM_DEPTH];
    logic [SOCK_N-1:0][SIRQ_W-1:0] sock_flags, next_sock_flags;
    logic common_coll, next_common_coll;
    logic [DATA_W-1:0] irq_mask, next_irq_mask, wr_hold, next_wr_hold;
    logic [LEN_W-1:0] tx_len, next_tx_len, rx_len, next_rx_len;
    nopi_tx_state_t tx_state, next_tx_state;
    logic [MEM_AW-1:0] tx_idx, next_tx_idx;
    logic [2*DATA_W-1:0] tx_hold, next_tx_hold;
    logic tx_last, next_tx_last, next_tx_req, tx_half, next_tx_half;
    logic [LEN_W-1:0] rx_wr, next_rx_wr;
    logic byte_seen, next_byte_seen, eop_seen, next_eop_seen;
    logic rd_act_d, wr_act_d;
    logic [ADDR_W-1:0] rd_addr, next_rd_addr;
    logic [DATA_W-1:0] next_data_out;
    logic next_int_n;
    logic rd_active, wr_active, rd_done, wr_done, full_dup, coll_ev, clr_common;
    logic byte_ev, eop_ev, tx_mem_we, rx_mem_we;
    logic [DATA_W-1:0] common_flags, rd_val;
    logic [SOCK_N-1:0] sock_pend;

    assign full_dup = !dup_n_s;
    assign rd_active = !cs_n_s && !rd_n_s;
    assign wr_active = !cs_n_s && !wr_n_s;
    assign rd_done = rd_act_d && !rd_active;
    assign wr_done = wr_act_d && !wr_active;
    assign coll_ev = col_s && !full_dup;
    assign byte_ev = rx_tgl_s[0] != byte_seen;
    assign eop_ev = rx_tgl_s[1] != eop_seen;
    assign clr_common = rd_done && (rd_addr == ADDR_COMMON_IRQ);
    assign tx_mem_we = wr_done && nopi_in_page(addr_s, TX_MEM_PAGE);
    assign rx_mem_we = byte_ev && (rx_wr < LEN_MAX);
    always_comb begin
        for (int n = 0; n < SOCK_N; n++) begin
            sock_pend[n] = |sock_flags[n];
        end
    end
    assign common_flags = {common_coll, 3'h0, sock_pend};

    // host read mux over the address map
    always_comb begin
        rd_val = '0;
        if (addr_s == ADDR_COMMON_IRQ) begin
            rd_val = common_flags;
        end else if (addr_s == ADDR_IRQ_MASK) begin
            rd_val = irq_mask;
        end else if (nopi_is_sock_irq(addr_s)) begin
            rd_val = {4'h0, sock_flags[addr_s[9:8]]};
        end else if (addr_s == ADDR_TX_LEN) begin
            rd_val = tx_len;
        end else if (addr_s == ADDR_RX_LEN) begin
            rd_val = rx_len;
        end else if (addr_s == ADDR_LINK_STAT) begin
            rd_val = '0;
            rd_val[STAT_CARRIER] = carrier_s;
            rd_val[STAT_FULL_DUP] = full_dup;
            rd_val[STAT_TX_BUSY] = (tx_state != NOPI_TX_IDLE);
        end else if (nopi_in_page(addr_s, TX_MEM_PAGE)) begin
            rd_val = tx_mem[addr_s[MEM_AW-1:0]];
        end else if (nopi_in_page(addr_s, RX_MEM_PAGE)) begin
            rd_val = rx_mem[addr_s[MEM_AW-1:0]];
        end
    end

    // next values for host registers, interrupts, transmit control and receive store
    always_comb begin
        logic [SIRQ_W-1:0] set_v;
        logic clr_s;
        set_v = '0;
        clr_s = 1'b0;
        next_wr_hold = wr_active ? data_s : wr_hold;
        next_rd_addr = rd_active ? addr_s : rd_addr;
        next_data_out = rd_active ? rd_val : data_out;
        next_irq_mask = irq_mask;
        next_tx_len = tx_len;
        if (wr_done && addr_s == ADDR_IRQ_MASK) begin
            next_irq_mask = wr_hold;
        end
        if (wr_done && addr_s == ADDR_TX_LEN) begin
            next_tx_len = (wr_hold > LEN_MAX) ? LEN_MAX : wr_hold;
        end
        // set beats clear when an event lands on the clearing read
        next_common_coll = coll_ev || (common_coll && !clr_common);
        for (int n = 0; n < SOCK_N; n++) begin
            set_v = '0;
            set_v[SIR_CONNECT] = event_connect_in[n];
            set_v[SIR_DISCON] = event_disconnect_in[n];
            set_v[SIR_RECV] = event_recv_in[n] || (n == 0 && eop_ev);
            set_v[SIR_TIMEOUT] = event_timeout_in[n];
            clr_s = clr_common || (rd_done && nopi_is_sock_irq(rd_addr)
                && rd_addr[9:8] == 2'(n));
            next_sock_flags[n] = set_v | (clr_s ? '0 : sock_flags[n]);
        end
        next_int_n = !(|(common_flags & irq_mask));
        // receive store: bytes arrive by toggle, packet end latches length
        next_byte_seen = rx_tgl_s[0];
        next_eop_seen = rx_tgl_s[1];
        next_rx_wr = rx_mem_we ? rx_wr + 1'b1 : rx_wr;
        next_rx_len = rx_len;
        if (eop_ev) begin
            next_rx_len = next_rx_wr;
            next_rx_wr = '0;
        end
        // transmit feed: up to two bytes per request toggle, next pair only after ack
        next_tx_state = tx_state;
        next_tx_idx = tx_idx;
        next_tx_hold = tx_hold;
        next_tx_half = tx_half;
        next_tx_last = tx_last;
        next_tx_req = tx_req;
        unique case (tx_state)
            NOPI_TX_IDLE: begin
                if (wr_done && addr_s == ADDR_TX_CMD && wr_hold == CMD_SEND && tx_len != '0) begin
                    next_tx_state = NOPI_TX_DEFER;
                end
            end
            NOPI_TX_DEFER: begin
                // an aborted frame may leave a request in flight: wait for its ack first
                if (!(carrier_s && !full_dup) && tx_ack_s == tx_req) begin
                    next_tx_idx = '0;
                    next_tx_hold = {tx_mem[1], tx_mem[0]};
                    next_tx_half = (tx_len == 8'h01);
                    next_tx_last = (tx_len <= 8'h02);
                    next_tx_req = !tx_req;
                    next_tx_state = NOPI_TX_SEND;
                end
            end
            NOPI_TX_SEND: begin
                if (coll_ev) begin
                    next_tx_state = NOPI_TX_IDLE;
                end else if (tx_ack_s == tx_req) begin
                    if (tx_last) begin
                        next_tx_state = NOPI_TX_IDLE;
                    end else begin
                        next_tx_idx = tx_idx + 6'h02;
                        next_tx_hold = {tx_mem[tx_idx + 6'h03], tx_mem[tx_idx + 6'h02]};
                        next_tx_half = (LEN_W'(tx_idx) + 8'h03 == tx_len);
                        next_tx_last = (LEN_W'(tx_idx) + 8'h04 >= tx_len);
                        next_tx_req = !tx_req;
                    end
                end
            end
            default: next_tx_state = NOPI_TX_IDLE;
        endcase
    end

    // core registers; buffers carry no reset
    always_ff @(posedge clock_in) begin
        if (tx_mem_we) begin
            tx_mem[addr_s[MEM_AW-1:0]] <= wr_hold;
        end
        if (rx_mem_we) begin
            rx_mem[rx_wr[MEM_AW-1:0]] <= rx_byte;
        end
        if (core_rst) begin
            sock_flags <= '0;
            common_coll <= 1'b0;
            irq_mask <= MASK_RST;
            wr_hold <= '0;
            tx_len <= '0;
            rx_len <= '0;
            tx_state <= NOPI_TX_IDLE;
            tx_idx <= '0;
            tx_hold <= '0;
            tx_half <= 1'b0;
            tx_last <= 1'b0;
            tx_req <= 1'b0;
            rx_wr <= '0;
            byte_seen <= 1'b0;
            eop_seen <= 1'b0;
            rd_act_d <= 1'b0;
            wr_act_d <= 1'b0;
            rd_addr <= '0;
            data_out <= '0;
            data_oe_out <= 1'b0;
            int_n_out <= 1'b1;
        end else begin
            sock_flags <= next_sock_flags;
            common_coll <= next_common_coll;
            irq_mask <= next_irq_mask;
            wr_hold <= next_wr_hold;
            tx_len <= next_tx_len;
            rx_len <= next_rx_len;
            tx_state <= next_tx_state;
            tx_idx <= next_tx_idx;
            tx_hold <= next_tx_hold;
            tx_half <= next_tx_half;
            tx_last <= next_tx_last;
            tx_req <= next_tx_req;
            rx_wr <= next_rx_wr;
            byte_seen <= next_byte_seen;
            eop_seen <= next_eop_seen;
            rd_act_d <= rd_active;
            wr_act_d <= wr_active;
            rd_addr <= next_rd_addr;
            data_out <= next_data_out;
            data_oe_out <= rd_active;
            int_n_out <= next_int_n;
        end
    end

    // transmit link: tx_hold and tx_half hold from request toggle to ack, so no word sync
    // up to two bytes per request: the toggle round trip fits in four nibble times, so frames
    // stay gapless at the slow nibble rate; the fast rate still underruns on this core clock
    logic [2*DATA_W-1:0] tx_sh, next_tx_sh;
    logic [1:0] tx_rem, next_tx_rem;
    logic [NIB_W-1:0] next_tx_data;
    logic next_tx_valid, next_tx_seen;
    always_comb begin
        next_tx_seen = tx_seen;
        next_tx_sh = tx_sh;
        next_tx_rem = tx_rem;
        next_tx_valid = 1'b0;
        next_tx_data = tx_data_out;
        if (tx_rem != 2'h0) begin
            next_tx_valid = 1'b1;
            next_tx_data = tx_sh[NIB_W-1:0];
            next_tx_sh = tx_sh >> NIB_W;
            next_tx_rem = tx_rem - 2'h1;
        end else if (tx_req_s != tx_seen) begin
            next_tx_seen = tx_req_s;
            next_tx_sh = tx_hold >> NIB_W;
            next_tx_rem = tx_half ? 2'h1 : 2'h3;
            next_tx_valid = 1'b1;
            next_tx_data = tx_hold[NIB_W-1:0];
        end
    end
    always_ff @(posedge tx_nibble_clock_in) begin
        if (tx_rst) begin
            tx_seen <= 1'b0;
            tx_sh <= '0;
            tx_rem <= 2'h0;
            tx_valid_out <= 1'b0;
            tx_data_out <= '0;
        end else begin
            tx_seen <= next_tx_seen;
            tx_sh <= next_tx_sh;
            tx_rem <= next_tx_rem;
            tx_valid_out <= next_tx_valid;
            tx_data_out <= next_tx_data;
        end
    end

    // receive link: pair nibbles low first, byte held two nibble times for the core
    logic rx_v_q, rx_v_d, rx_have_lo;
    logic [NIB_W-1:0] rx_d_q, rx_lo;
    logic next_rx_have_lo, next_rx_byte_tgl, next_rx_eop_tgl;
    logic [NIB_W-1:0] next_rx_lo;
    logic [DATA_W-1:0] next_rx_byte;
    always_comb begin
        next_rx_have_lo = rx_have_lo;
        next_rx_lo = rx_lo;
        next_rx_byte = rx_byte;
        next_rx_byte_tgl = rx_byte_tgl;
        next_rx_eop_tgl = rx_eop_tgl;
        if (rx_v_q) begin
            if (!rx_have_lo) begin
                next_rx_lo = rx_d_q;
                next_rx_have_lo = 1'b1;
            end else begin
                next_rx_byte = {rx_d_q, rx_lo};
                next_rx_have_lo = 1'b0;
                next_rx_byte_tgl = !rx_byte_tgl;
            end
        end else if (rx_v_d) begin
            next_rx_eop_tgl = !rx_eop_tgl; // odd trailing nibble is dropped
            next_rx_have_lo = 1'b0;
        end
    end
    always_ff @(posedge rx_nibble_clock_in) begin
        if (rx_rst) begin
            rx_v_q <= 1'b0;
            rx_v_d <= 1'b0;
            rx_d_q <= '0;
            rx_have_lo <= 1'b0;
            rx_lo <= '0;
            rx_byte <= '0;
            rx_byte_tgl <= 1'b0;
            rx_eop_tgl <= 1'b0;
        end else begin
            rx_v_q <= rx_valid_in;
            rx_v_d <= rx_v_q;
            rx_d_q <= rx_data_in;
            rx_have_lo <= next_rx_have_lo;
            rx_lo <= next_rx_lo;
            rx_byte <= next_rx_byte;
            rx_byte_tgl <= next_rx_byte_tgl;
            rx_eop_tgl <= next_rx_eop_tgl;
        end
    end

    // checks
    int_assert_a: assert property (@(posedge clock_in) disable iff (core_rst)
        (|(common_flags & irq_mask)) |=> !int_n_out) else $error("pending irq not signalled");
    int_masked_a: assert property (@(posedge clock_in) disable iff (core_rst)
        !(|(common_flags & irq_mask)) |=> int_n_out) else $error("masked irq asserted pin");
    read_clear_a: assert property (@(posedge clock_in) disable iff (core_rst)
        clr_common && !coll_ev |=> !common_coll) else $error("common read did not clear");
    col_ignore_a: assert property (@(posedge clock_in) disable iff (core_rst)
        full_dup && !common_coll |=> !common_coll) else $error("collision used in full duplex");
    write_latch_a: assert property (@(posedge clock_in) disable iff (core_rst)
        wr_done && addr_s == ADDR_IRQ_MASK |=> irq_mask == $past(wr_hold))
        else $error("mask write not latched");
    read_drive_a: assert property (@(posedge clock_in) disable iff (core_rst)
        rd_active ##1 rd_active |=> data_oe_out && data_out == $past(rd_val))
        else $error("read data not driven");
    pin_reset_a: assert property (@(posedge clock_in) disable iff (rst_in)
        pin_rst |=> irq_mask == MASK_RST && !common_coll && tx_state == NOPI_TX_IDLE)
        else $error("pin reset left state");
    carrier_defer_a: assert property (@(posedge clock_in) disable iff (core_rst)
        tx_state == NOPI_TX_DEFER && carrier_s && !full_dup |=> tx_state == NOPI_TX_DEFER)
        else $error("sent while carrier present");
    tx_nibble_a: assert property (@(posedge tx_nibble_clock_in) disable iff (tx_rst)
        tx_rem != 2'h0 |=> tx_valid_out && tx_data_out == NIB_W'($past(tx_sh)))
        else $error("queued nibble not sent");
    tx_start_a: assert property (@(posedge tx_nibble_clock_in) disable iff (tx_rst)
        tx_rem == 2'h0 && tx_req_s == tx_seen |=> !tx_valid_out)
        else $error("tx valid without nibble");
    rx_gate_a: assert property (@(posedge rx_nibble_clock_in) disable iff (rx_rst)
        !rx_v_q |=> $stable(rx_byte_tgl) && $stable(rx_byte)) else $error("byte outside valid");
endmodule

// ### dv/nopi_phy_model.sv
// mii phy model: free running nibble clocks, transmit capture, receive frames
`timescale 1ns/1ps
module nopi_phy_model (
    output logic tx_clk_out,
    output logic rx_clk_out,
    input wire logic tx_valid_in,
    input wire logic [3:0] tx_data_in,
    output logic rx_valid_out,
    output logic [3:0] rx_data_out
);
    logic [3:0] txq[$];
    logic tx_prev = 0;
    int tx_starts = 0;
    // clocks run free; rx phase offset so neither lines up with the core
    initial begin
        tx_clk_out = 0;
        rx_clk_out = 0;
        rx_valid_out = 0;
        rx_data_out = 4'h5;
        fork
            forever #80 tx_clk_out = ~tx_clk_out;
            #33 forever #80 rx_clk_out = ~rx_clk_out;
        join
    end
    // phy samples transmit nibbles on the rising edge; a second rise in one frame is a gap
    always @(posedge tx_clk_out) begin
        if (tx_valid_in === 1'b1) txq.push_back(tx_data_in);
        if (tx_valid_in === 1'b1 && tx_prev !== 1'b1) tx_starts++;
        tx_prev = tx_valid_in;
    end
    // launched on the falling edge, low nibble first; stale data inverted after
    task automatic send(input logic [7:0] b[$]);
        foreach (b[i]) for (int h = 0; h < 2; h++) begin
            @(negedge rx_clk_out);
            rx_valid_out = 1;
            rx_data_out = h ? b[i][7:4] : b[i][3:0];
        end
        @(negedge rx_clk_out);
        rx_valid_out = 0;
        rx_data_out = ~rx_data_out;
    endtask
endmodule

// ### dv/tb_nopi_top.sv
// self-checking bench for the pin boundary with a mii phy model
`timescale 1ns/1ps
module tb_nopi_top;
    import nopi_pkg::*;
    logic clk = 0, rst = 1, pin_n = 1, coll = 0, carrier_present = 0, dup_n = 0;
    logic cs_n = 1, rd_n = 1, wr_n = 1, tx_nibble_clock, rx_nibble_clock, rxv, txv, oe, int_n;
    logic [3:0] ev_c = 0, ev_d = 0, ev_r = 0, ev_t = 0, rxd, txd;
    logic [14:0] addr = 0;
    logic [7:0] din = 0, dout;
    logic [7:0] q[$];
    int num_errors = 0, comparisons = 0;
    always #12.5 clk = ~clk;
    nopi_top #(.RST_MIN_CYCLES(20)) DUT (.clock_in(clk), .rst_in(rst), .reset_pin_n_in(pin_n),
        .tx_nibble_clock_in(tx_nibble_clock), .tx_valid_out(txv), .tx_data_out(txd), .rx_nibble_clock_in(rx_nibble_clock),
        .rx_valid_in(rxv), .rx_data_in(rxd), .collision_in(coll), .carrier_present_in(carrier_present),
        .duplex_select_n_in(dup_n), .addr_in(addr), .data_in(din), .data_out(dout),
        .data_oe_out(oe), .chip_select_n_in(cs_n), .read_n_in(rd_n), .write_n_in(wr_n),
        .int_n_out(int_n), .event_connect_in(ev_c), .event_disconnect_in(ev_d),
        .event_recv_in(ev_r), .event_timeout_in(ev_t));
    nopi_phy_model phy (.tx_clk_out(tx_nibble_clock), .rx_clk_out(rx_nibble_clock), .tx_valid_in(txv),
        .tx_data_in(txd), .rx_valid_out(rxv), .rx_data_out(rxd));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // strobe low six cycles then idle six, both above the minimum of four
    task automatic acc(input logic [14:0] a, input logic [7:0] d, input logic w, input logic [7:0] e);
        @(negedge clk);
        addr = a;
        din = d;
        cs_n = 0;
        rd_n = w;
        wr_n = !w;
        repeat (6) @(negedge clk);
        if (!w) chk({7'h00, oe}, 8'h01);
        if (!w) chk(dout, e);
        {cs_n, rd_n, wr_n} = 3'b111;
        repeat (6) @(negedge clk);
    endtask
    task automatic pulse(input logic [15:0] v);
        @(negedge clk);
        {ev_t, ev_r, ev_d, ev_c} = v;
        @(negedge clk);
        {ev_t, ev_r, ev_d, ev_c} = 16'h0000;
        repeat (3) @(negedge clk);
    endtask
    // random frame into the transmit buffer, then length and send command
    task automatic txload(input int n);
        q = {};
        for (int i = 0; i < n; i++) begin
            q.push_back(8'($urandom));
            acc(15'(16'h4000 + i), q[i], 1, 0);
        end
        acc(ADDR_TX_LEN, 8'(n), 1, 0);
        acc(ADDR_TX_CMD, CMD_SEND, 1, 0);
    endtask
    // extra idle wait also catches nibbles after the last one
    task automatic txcheck;
        for (int k = 0; k < 4000 && phy.txq.size() < 2 * q.size(); k++) @(negedge clk);
        repeat (40) @(negedge clk);
        chk(8'(phy.txq.size()), 8'(2 * q.size()));
        foreach (q[i]) chk({phy.txq[2*i+1], phy.txq[2*i]}, q[i]);
        chk({7'h00, txv}, 8'h00);
        chk(8'(phy.tx_starts), 8'h01);
        phy.txq = {};
        phy.tx_starts = 0;
    endtask
    initial begin
        #1000000;
        num_errors++;
        give_verdict();
    end
    initial begin
        void'($urandom(23701));
        repeat (10) @(negedge clk);
        rst = 0;
        repeat (8) @(negedge clk);
        chk({6'h00, int_n, oe}, 8'h02);
        acc(ADDR_IRQ_MASK, 0, 0, MASK_RST);
        acc(15'h0100, 0, 0, 8'h00);
        $display("reset and decode test done");
        acc(ADDR_IRQ_MASK, 8'h03, 1, 0);
        pulse(16'h0040);
        chk({7'h00, int_n}, 8'h01);
        pulse(16'h0201);
        chk({7'h00, int_n}, 8'h00);
        acc(15'h0502, 0, 0, 8'h04);
        chk({7'h00, int_n}, 8'h00);
        acc(ADDR_COMMON_IRQ, 0, 0, 8'h05);
        chk({7'h00, int_n}, 8'h01);
        pulse(16'h1000);
        acc(15'h0402, 0, 0, 8'h08);
        chk({7'h00, int_n}, 8'h01);
        $display("interrupt test done");
        coll = 1;
        txload(1 + $urandom % 8);
        txcheck();
        acc(ADDR_COMMON_IRQ, 0, 0, 8'h00);
        coll = 0;
        dup_n = 1;
        carrier_present = 1;
        repeat (4) @(negedge clk);
        acc(ADDR_LINK_STAT, 0, 0, 8'h01);
        txload(8);
        repeat (200) @(negedge clk);
        chk(8'(phy.txq.size()), 8'h00);
        acc(ADDR_LINK_STAT, 0, 0, 8'h05);
        carrier_present = 0;
        txcheck();
        txload(8);
        for (int k = 0; k < 4000 && txv !== 1'b1; k++) @(negedge clk);
        coll = 1;
        repeat (200) @(negedge clk);
        coll = 0;
        chk({7'h00, txv}, 8'h00);
        chk(8'(phy.txq.size() < 16), 8'h01);
        acc(ADDR_COMMON_IRQ, 0, 0, 8'h80);
        phy.txq = {};
        phy.tx_starts = 0;
        $display("transmit test done");
        q = {};
        repeat (1 + $urandom % 8) q.push_back(8'($urandom));
        q[0] = 8'hF0;
        phy.send(q);
        repeat (20) @(negedge clk);
        acc(ADDR_RX_LEN, 0, 0, 8'(q.size()));
        foreach (q[i]) acc(15'(16'h6000 + i), 0, 0, q[i]);
        acc(15'h0402, 0, 0, 8'h04);
        $display("receive test done");
        acc(ADDR_IRQ_MASK, 8'hFF, 1, 0);
        pin_n = 0;
        repeat (10) @(negedge clk);
        pin_n = 1;
        repeat (10) @(negedge clk);
        acc(ADDR_IRQ_MASK, 0, 0, 8'hFF);
        pin_n = 0;
        repeat (40) @(negedge clk);
        pin_n = 1;
        repeat (10) @(negedge clk);
        acc(ADDR_IRQ_MASK, 0, 0, MASK_RST);
        $display("pin reset test done");
        give_verdict();
    end
endmodule

// ### pkg/nopi_pkg.sv
// shared constants, address map and types for the network offload pin interface
package nopi_pkg;
    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    localparam int NIB_W = 4;
    localparam int SOCK_N = 4;
    localparam int SIRQ_W = 4;
    localparam int MEM_AW = 6;
    localparam int MEM_DEPTH = 64;
    localparam int LEN_W = 8;

    // core clock and minimum pin reset width
    localparam int CORE_CLK_KHZ = 40000;
    localparam int RST_MIN_NS = 125000;
    localparam int RST_MIN_CYC = (RST_MIN_NS * (CORE_CLK_KHZ / 1000) + 999) / 1000;
    localparam int RST_CNT_W = 16;

    // host address map
    localparam logic [ADDR_W-1:0] ADDR_COMMON_IRQ = 15'h0015;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 15'h0016;
    localparam logic [ADDR_W-1:0] ADDR_TX_LEN = 15'h0030;
    localparam logic [ADDR_W-1:0] ADDR_TX_CMD = 15'h0031;
    localparam logic [ADDR_W-1:0] ADDR_LINK_STAT = 15'h0032;
    localparam logic [ADDR_W-1:0] ADDR_RX_LEN = 15'h0033;
    localparam logic [4:0] SOCK_PAGE = 5'h01;
    localparam logic [7:0] SOCK_IRQ_LO = 8'h02;
    localparam logic [8:0] TX_MEM_PAGE = 9'h100;
    localparam logic [8:0] RX_MEM_PAGE = 9'h180;

    // field layout and values
    localparam logic [DATA_W-1:0] CMD_SEND = 8'h20;
    localparam logic [LEN_W-1:0] LEN_MAX = 8'h40;
    localparam logic [DATA_W-1:0] MASK_RST = 8'h00;
    localparam int SIR_CONNECT = 0;
    localparam int SIR_DISCON = 1;
    localparam int SIR_RECV = 2;
    localparam int SIR_TIMEOUT = 3;
    localparam int COMMON_COLL_BIT = 7;
    localparam int STAT_CARRIER = 0;
    localparam int STAT_FULL_DUP = 1;
    localparam int STAT_TX_BUSY = 2;

    typedef enum logic [1:0] {
        NOPI_TX_IDLE = 2'b00,
        NOPI_TX_DEFER = 2'b01,
        NOPI_TX_SEND = 2'b10
    } nopi_tx_state_t;

    // per-socket interrupt register decode
    function automatic logic nopi_is_sock_irq(input logic [ADDR_W-1:0] a);
        return (a[14:10] == SOCK_PAGE) && (a[7:0] == SOCK_IRQ_LO);
    endfunction

    // 64-byte buffer window decode
    function automatic logic nopi_in_page(input logic [ADDR_W-1:0] a, input logic [8:0] page);
        return a[14:6] == page;
    endfunction
endpackage
